// ---- pkg/fcs_pkg.sv ----
// Constants, command codes and types of the flash command sequencer host.
// Assumes a single 20 MHz clock; all bus timing is counted in its cycles.
package fcs_pkg;

  // Clock rate and cycle rounding
  localparam int CLOCK_KHZ = 20000;

  // Least time in ns to whole cycles, never below one
  function automatic int cycles_min(input int ns);
    int c;
    c = (ns * CLOCK_KHZ + 999999) / 1000000;
    cycles_min = (c < 1) ? 1 : c;
  endfunction

  // Bus cycle timing, printed unit ns
  localparam int WE_PULSE_NS = 70;
  localparam int OE_ACCESS_NS = 150;
  localparam int RECOVERY_NS = 30;
  localparam logic [3:0] WE_PULSE_CYC = 4'(cycles_min(WE_PULSE_NS));
  localparam logic [3:0] OE_ACCESS_CYC = 4'(cycles_min(OE_ACCESS_NS));
  localparam logic [3:0] RECOVERY_CYC = 4'(cycles_min(RECOVERY_NS));
  localparam logic [3:0] SYNC_STAGES = 4'h3;

  // Command codes
  localparam logic [7:0] CMD_PROGRAM_SETUP = 8'h40;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_LOCK_SET_CONFIRM = 8'h01;
  localparam logic [7:0] CMD_PROT_SETUP = 8'hC0;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;

  // Operation status bit positions and values
  localparam int READY_BIT = 7;
  localparam int SUSPENDED_BIT = 6;
  localparam int ERASE_ERR_BIT = 5;
  localparam int PROG_ERR_BIT = 4;
  localparam int VOLT_ERR_BIT = 3;
  localparam int PROTECT_BIT = 1;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] ERROR_MASK = 8'h3A;

  // User operations
  typedef enum logic [3:0] {
    OP_PROGRAM,
    OP_ERASE,
    OP_SUSPEND,
    OP_RESUME,
    OP_LOCK_SET,
    OP_LOCK_CLEAR,
    OP_PROT_PROGRAM,
    OP_CLEAR_STATUS,
    OP_READ_ARRAY
  } fcs_op_t;

endpackage

// ---- pkg/fcs_cyc_if.sv ----
// Request/answer bundle between the sequencer and the bus cycle engine.
// Assumes both ends share one clock; req and done are one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none
interface fcs_cyc_if #(
  parameter int ADDR_W = 24,
  parameter int DATA_W = 16
) ();
  logic req;
  logic write;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic done;
  logic [DATA_W-1:0] rdata;

  modport master(output req, write, addr, wdata, input done, rdata);
  modport slave(input req, write, addr, wdata, output done, rdata);
endinterface
`default_nettype wire

// ---- logic/fcs_bus_cycle.sv ----
// Single asynchronous bus cycle engine: one write or read per request.
// Assumes the requester waits for done before the next request.
`timescale 1ns/10ps
`default_nettype none
module fcs_bus_cycle #(
  parameter int ADDR_W = 24,
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Sequencer side
  fcs_cyc_if.slave cyc,
  // Flash pins
  output logic [ADDR_W-1:0] o_addr,
  output logic [DATA_W-1:0] o_dq,
  output logic o_dq_oe,
  input wire logic [DATA_W-1:0] i_dq,
  output logic o_ce_b,
  output logic o_oe_b,
  output logic o_we_b
);

  typedef enum {BC_IDLE, BC_SETUP, BC_STROBE, BC_SAMPLE, BC_RECOVER} fcs_bc_state_t;

  fcs_bc_state_t state;
  logic [3:0] count;
  logic is_write;
  logic [DATA_W-1:0] dq_s1;
  logic [DATA_W-1:0] dq_s2;
  logic [DATA_W-1:0] dq_s3;

  // Read data synchroniser; only stages two and three are compared
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dq_s1 <= '0;
      dq_s2 <= '0;
      dq_s3 <= '0;
    end else begin
      dq_s1 <= i_dq;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
    end
  end

  // Cycle sequencing; OE rises after every read so each poll is a fresh toggle
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= BC_IDLE;
      count <= 4'h0;
      is_write <= 1'b0;
      o_addr <= '0;
      o_dq <= '0;
      o_dq_oe <= 1'b0;
      o_ce_b <= 1'b1;
      o_oe_b <= 1'b1;
      o_we_b <= 1'b1;
      cyc.done <= 1'b0;
      cyc.rdata <= '0;
    end else begin
      cyc.done <= 1'b0;
      case (state)
        BC_IDLE: begin
          if (cyc.req) begin
            o_addr <= cyc.addr;
            o_dq <= cyc.wdata;
            o_dq_oe <= cyc.write;
            is_write <= cyc.write;
            o_ce_b <= 1'b0;
            state <= BC_SETUP;
          end
        end
        BC_SETUP: begin
          if (is_write) begin
            o_we_b <= 1'b0;
            count <= fcs_pkg::WE_PULSE_CYC - 4'h1;
          end else begin
            o_oe_b <= 1'b0;
            // Pipeline lag of the synchroniser is added to the access time
            count <= fcs_pkg::OE_ACCESS_CYC + fcs_pkg::SYNC_STAGES - 4'h1;
          end
          state <= BC_STROBE;
        end
        BC_STROBE: begin
          if (count == 4'h0) begin
            if (is_write) begin
              o_we_b <= 1'b1;
              count <= fcs_pkg::RECOVERY_CYC - 4'h1;
              state <= BC_RECOVER;
            end else begin
              state <= BC_SAMPLE;
            end
          end else begin
            count <= count - 4'h1;
          end
        end
        BC_SAMPLE: begin
          if (dq_s2 == dq_s3) begin
            cyc.rdata <= dq_s3;
            o_oe_b <= 1'b1;
            count <= fcs_pkg::RECOVERY_CYC - 4'h1;
            state <= BC_RECOVER;
          end
        end
        BC_RECOVER: begin
          if (count == 4'h0) begin
            o_ce_b <= 1'b1;
            o_dq_oe <= 1'b0;
            cyc.done <= 1'b1;
            state <= BC_IDLE;
          end else begin
            count <= count - 4'h1;
          end
        end
        default: state <= BC_IDLE;
      endcase
    end
  end

  // Strobes never overlap
  property p_strobe_exclusive;
    @(posedge i_clock) disable iff (!i_rst_b) !(!o_we_b && !o_oe_b);
  endproperty
  a_strobe_exclusive: assert property (p_strobe_exclusive) else $error("WE and OE low together");

  // Write pulse lasts exactly the computed width
  property p_we_width;
    @(posedge i_clock) disable iff (!i_rst_b) $fell(o_we_b) |-> !o_we_b [*2] ##1 o_we_b;
  endproperty
  a_we_width: assert property (p_we_width) else $error("Write pulse width wrong");

  // Every cycle ends with strobes released, so the next read toggles OE
  property p_done_released;
    @(posedge i_clock) disable iff (!i_rst_b) cyc.done |-> o_oe_b && o_we_b && o_ce_b;
  endproperty
  a_done_released: assert property (p_done_released) else $error("Strobe held");

endmodule
`default_nettype wire

// ---- logic/fcs_flash_host.sv ----
// Host-side command sequencer driving a parallel flash through its pins.
// Assumes the user holds i_op_valid until taken; one flash, always enabled.
`timescale 1ns/10ps
`default_nettype none
module fcs_flash_host #(
  parameter int ADDR_W = 24,
  parameter int DATA_W = 16,
  parameter logic [7:0] CLEAR_STATUS_CODE = 8'h50
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // User orders
  input wire logic i_op_valid,
  input wire fcs_pkg::fcs_op_t i_op_code,
  input wire logic [ADDR_W-1:0] i_op_addr,
  input wire logic [DATA_W-1:0] i_op_data,
  input wire logic i_powerdown,
  output logic o_op_ready,
  output logic o_suspend_ready,
  output logic o_op_done,
  // Reported status
  output logic [7:0] o_status,
  output logic o_device_ready,
  output logic o_suspended,
  output logic o_voltage_error,
  output logic o_protect_error,
  output logic o_program_error,
  output logic o_erase_error,
  output logic o_sequence_error,
  output logic o_device_busy,
  // Flash pins
  output logic [ADDR_W-1:0] o_flash_addr,
  output logic [DATA_W-1:0] o_flash_dq,
  output logic o_flash_dq_oe,
  input wire logic [DATA_W-1:0] i_flash_dq,
  output logic o_flash_ce_b,
  output logic o_flash_oe_b,
  output logic o_flash_we_b,
  output logic o_flash_rp_b,
  input wire logic i_busy_indicator_pin
);

  typedef enum {ST_IDLE, ST_FIRST, ST_SECOND, ST_POLL, ST_RETURN} fcs_state_t;

  fcs_cyc_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) cyc ();

  fcs_state_t state;
  fcs_pkg::fcs_op_t cur_op;
  logic [DATA_W-1:0] cur_data;
  logic [7:0] next_status;
  logic poll_ok;
  logic clear_done;
  logic take_op;
  logic take_suspend;
  logic sts_s1;
  logic sts_s2;
  logic sts_s3;

  fcs_bus_cycle #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_bus (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .cyc(cyc.slave),
    .o_addr(o_flash_addr),
    .o_dq(o_flash_dq),
    .o_dq_oe(o_flash_dq_oe),
    .i_dq(i_flash_dq),
    .o_ce_b(o_flash_ce_b),
    .o_oe_b(o_flash_oe_b),
    .o_we_b(o_flash_we_b)
  );

  // First write of each operation
  function automatic logic [DATA_W-1:0] first_word(input fcs_pkg::fcs_op_t op);
    case (op)
      fcs_pkg::OP_PROGRAM: first_word = DATA_W'(fcs_pkg::CMD_PROGRAM_SETUP);
      fcs_pkg::OP_ERASE: first_word = DATA_W'(fcs_pkg::CMD_ERASE_SETUP);
      fcs_pkg::OP_SUSPEND: first_word = DATA_W'(fcs_pkg::CMD_SUSPEND);
      fcs_pkg::OP_RESUME: first_word = DATA_W'(fcs_pkg::CMD_CONFIRM);
      fcs_pkg::OP_LOCK_SET: first_word = DATA_W'(fcs_pkg::CMD_LOCK_SETUP);
      fcs_pkg::OP_LOCK_CLEAR: first_word = DATA_W'(fcs_pkg::CMD_LOCK_SETUP);
      fcs_pkg::OP_PROT_PROGRAM: first_word = DATA_W'(fcs_pkg::CMD_PROT_SETUP);
      fcs_pkg::OP_CLEAR_STATUS: first_word = DATA_W'(CLEAR_STATUS_CODE);
      default: first_word = DATA_W'(fcs_pkg::CMD_READ_ARRAY);
    endcase
  endfunction

  // Second write of a two-cycle operation
  function automatic logic [DATA_W-1:0] second_word(input fcs_pkg::fcs_op_t op,
                                                    input logic [DATA_W-1:0] data);
    case (op)
      fcs_pkg::OP_ERASE: second_word = DATA_W'(fcs_pkg::CMD_CONFIRM);
      fcs_pkg::OP_LOCK_SET: second_word = DATA_W'(fcs_pkg::CMD_LOCK_SET_CONFIRM);
      fcs_pkg::OP_LOCK_CLEAR: second_word = DATA_W'(fcs_pkg::CMD_CONFIRM);
      default: second_word = data;
    endcase
  endfunction

  // Operations that take a second write
  function automatic logic two_cycle(input fcs_pkg::fcs_op_t op);
    case (op)
      fcs_pkg::OP_PROGRAM, fcs_pkg::OP_ERASE, fcs_pkg::OP_LOCK_SET,
      fcs_pkg::OP_LOCK_CLEAR, fcs_pkg::OP_PROT_PROGRAM: two_cycle = 1'b1;
      default: two_cycle = 1'b0;
    endcase
  endfunction

  // Order acceptance; only a suspend may cut into a running operation
  assign take_op = i_op_valid && o_op_ready && !i_powerdown;
  assign take_suspend = i_op_valid && o_suspend_ready && (i_op_code == fcs_pkg::OP_SUSPEND);
  assign poll_ok = (state == ST_POLL) && cyc.done && cyc.rdata[fcs_pkg::READY_BIT];
  assign clear_done = (state == ST_FIRST) && cyc.done && (cur_op == fcs_pkg::OP_CLEAR_STATUS);

  // Sequencer: command writes, status polling, return to array mode
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= ST_IDLE;
      cur_op <= fcs_pkg::OP_READ_ARRAY;
      cur_data <= '0;
      cyc.req <= 1'b0;
      cyc.write <= 1'b0;
      cyc.addr <= '0;
      cyc.wdata <= '0;
      o_op_ready <= 1'b1;
      o_suspend_ready <= 1'b0;
      o_op_done <= 1'b0;
    end else begin
      cyc.req <= 1'b0;
      o_op_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          o_op_ready <= !i_powerdown;
          if (take_op) begin
            cur_op <= i_op_code;
            cur_data <= i_op_data;
            cyc.req <= 1'b1;
            cyc.write <= 1'b1;
            cyc.addr <= i_op_addr;
            cyc.wdata <= first_word(i_op_code);
            o_op_ready <= 1'b0;
            state <= ST_FIRST;
          end
        end
        ST_FIRST: begin
          if (cyc.done) begin
            cyc.req <= two_cycle(cur_op) || (cur_op == fcs_pkg::OP_SUSPEND) ||
                       (cur_op == fcs_pkg::OP_RESUME);
            if (two_cycle(cur_op)) begin
              // Same address for both writes of the pair
              cyc.wdata <= second_word(cur_op, cur_data);
              state <= ST_SECOND;
            end else if ((cur_op == fcs_pkg::OP_SUSPEND) ||
                         (cur_op == fcs_pkg::OP_RESUME)) begin
              cyc.write <= 1'b0;
              o_suspend_ready <= (cur_op == fcs_pkg::OP_RESUME);
              state <= ST_POLL;
            end else begin
              o_op_done <= 1'b1;
              o_op_ready <= !i_powerdown;
              state <= ST_IDLE;
            end
          end
        end
        ST_SECOND: begin
          if (cyc.done) begin
            cyc.req <= 1'b1;
            cyc.write <= 1'b0;
            o_suspend_ready <= (cur_op == fcs_pkg::OP_PROGRAM) ||
                               (cur_op == fcs_pkg::OP_ERASE);
            state <= ST_POLL;
          end
        end
        ST_POLL: begin
          if (poll_ok) begin
            cyc.req <= 1'b1;
            cyc.write <= 1'b1;
            cyc.wdata <= DATA_W'(fcs_pkg::CMD_READ_ARRAY);
            o_suspend_ready <= 1'b0;
            state <= ST_RETURN;
          end else if (cyc.done && take_suspend) begin
            cur_op <= fcs_pkg::OP_SUSPEND;
            cyc.req <= 1'b1;
            cyc.write <= 1'b1;
            cyc.wdata <= DATA_W'(fcs_pkg::CMD_SUSPEND);
            o_suspend_ready <= 1'b0;
            state <= ST_FIRST;
          end else if (cyc.done) begin
            cyc.req <= 1'b1;
          end
        end
        ST_RETURN: begin
          if (cyc.done) begin
            o_op_done <= 1'b1;
            o_op_ready <= !i_powerdown;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Status shadow: errors stay until the next ready poll reloads it, a clear-status order or power-down
  always_comb begin
    next_status = o_status;
    if (i_powerdown) begin
      next_status = fcs_pkg::STATUS_RESET;
    end else if (poll_ok) begin
      next_status = cyc.rdata[7:0];
    end else if (clear_done) begin
      next_status = o_status & ~fcs_pkg::ERROR_MASK;
    end
  end

  // Registered status and decoded flags
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_status <= fcs_pkg::STATUS_RESET;
      o_device_ready <= 1'b0;
      o_suspended <= 1'b0;
      o_voltage_error <= 1'b0;
      o_protect_error <= 1'b0;
      o_program_error <= 1'b0;
      o_erase_error <= 1'b0;
      o_sequence_error <= 1'b0;
    end else begin
      o_status <= next_status;
      o_device_ready <= next_status[fcs_pkg::READY_BIT];
      o_suspended <= next_status[fcs_pkg::SUSPENDED_BIT];
      o_voltage_error <= next_status[fcs_pkg::VOLT_ERR_BIT];
      o_protect_error <= next_status[fcs_pkg::PROTECT_BIT];
      o_program_error <= next_status[fcs_pkg::PROG_ERR_BIT];
      o_erase_error <= next_status[fcs_pkg::ERASE_ERR_BIT];
      // Both errors together mean a bad command sequence
      o_sequence_error <= next_status[fcs_pkg::PROG_ERR_BIT] &&
                          next_status[fcs_pkg::ERASE_ERR_BIT];
    end
  end

  // Power-down pin follows the user request
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_flash_rp_b <= 1'b0;
    end else begin
      o_flash_rp_b <= !i_powerdown;
    end
  end

  // Busy pin synchroniser; a change counts once stages two and three agree
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sts_s1 <= 1'b1;
      sts_s2 <= 1'b1;
      sts_s3 <= 1'b1;
      o_device_busy <= 1'b0;
    end else begin
      sts_s1 <= i_busy_indicator_pin;
      sts_s2 <= sts_s1;
      sts_s3 <= sts_s2;
      if (sts_s2 == sts_s3) begin
        o_device_busy <= !sts_s3;
      end
    end
  end

  property p_prog_pair;
    @(posedge i_clock) disable iff (!i_rst_b)
      (state == ST_SECOND) && ($past(state) == ST_FIRST) && (cur_op == fcs_pkg::OP_PROGRAM)
      |-> ($past(cyc.wdata) == DATA_W'(fcs_pkg::CMD_PROGRAM_SETUP)) &&
          (cyc.wdata == cur_data) && (cyc.addr == $past(cyc.addr));
  endproperty
  a_prog_pair: assert property (p_prog_pair) else $error("Program pair malformed");

  property p_poll_busy;
    @(posedge i_clock) disable iff (!i_rst_b)
      (state == ST_POLL) && cyc.done && !cyc.rdata[fcs_pkg::READY_BIT]
      |=> cyc.req && !o_op_done && (state == ST_POLL || state == ST_FIRST);
  endproperty
  a_poll_busy: assert property (p_poll_busy) else $error("Busy status not re-polled");

  property p_return_array;
    @(posedge i_clock) disable iff (!i_rst_b)
      poll_ok |=> cyc.req && cyc.write && (cyc.wdata == DATA_W'(fcs_pkg::CMD_READ_ARRAY));
  endproperty
  a_return_array: assert property (p_return_array) else $error("No read-array write");

  property p_no_queue;
    @(posedge i_clock) disable iff (!i_rst_b) (state != ST_IDLE) |-> !o_op_ready;
  endproperty
  a_no_queue: assert property (p_no_queue) else $error("Order taken while busy");

  property p_suspend_flag;
    @(posedge i_clock) disable iff (!i_rst_b)
      poll_ok && !i_powerdown
      |=> (o_suspended == $past(cyc.rdata[fcs_pkg::SUSPENDED_BIT])) && o_device_ready;
  endproperty
  a_suspend_flag: assert property (p_suspend_flag) else $error("Suspend flag wrong");

  property p_sequence_error;
    @(posedge i_clock) disable iff (!i_rst_b)
      o_sequence_error |-> o_program_error && o_erase_error;
  endproperty
  a_sequence_error: assert property (p_sequence_error) else $error("Sequence flag");

  property p_powerdown;
    @(posedge i_clock) disable iff (!i_rst_b)
      i_powerdown |=> !o_flash_rp_b && (o_status == fcs_pkg::STATUS_RESET);
  endproperty
  a_powerdown: assert property (p_powerdown) else $error("Power-down not applied");

  property p_sticky;
    @(posedge i_clock) disable iff (!i_rst_b)
      !poll_ok && !clear_done && !i_powerdown
      |=> $stable(o_program_error) && $stable(o_voltage_error) && $stable(o_protect_error) &&
          $stable(o_erase_error);
  endproperty
  a_sticky: assert property (p_sticky) else $error("Error flag changed unprompted");

endmodule
`default_nettype wire

// ---- tb/fcs_flash_model.sv ----
// Behavioural parallel flash: command decode, status register, busy timing.
// Assumes host pins move on rising clock edges; they are sampled on falling ones.
`timescale 1ns/10ps
`default_nettype none
module fcs_flash_model #(
  parameter int BUSY_CYC = 200,
  parameter logic [7:0] CLEAR_CODE = 8'h50
) (
  // Host pins
  input wire logic i_clock,
  input wire logic [23:0] i_addr,
  input wire logic [15:0] i_dq,
  input wire logic i_ce_b,
  input wire logic i_oe_b,
  input wire logic i_we_b,
  input wire logic i_rp_b,
  // Fault injection
  input wire logic i_vpen_low,
  input wire logic i_locked,
  input wire logic i_fail,
  // Device outputs
  output logic [15:0] o_dq,
  output logic o_busy_low
);
  logic [7:0] sr = 8'h00;
  logic [7:0] shown = 8'h00;
  logic [7:0] pend = 8'h00;
  logic smode = 1'b0;
  logic oe_q = 1'b1;
  logic we_q = 1'b1;
  int busy = 0;
  int held = 0;
  int cyc = 0;
  logic [15:0] mem [int];
  // Released bus shows a moving pattern, so a late sample cannot pass
  assign o_dq = (!i_ce_b && !i_oe_b && i_rp_b) ?
                (smode ? {8'h00, shown} : 16'hFFFF) : 16'(cyc);
  assign o_busy_low = (busy > 0);
  // Command decoder, one completed write at a time
  task automatic take(input logic [23:0] a, input logic [15:0] w);
    // Clear-status leaves the read mode as it was
    if ((w[7:0] != CLEAR_CODE) || (pend != 8'h00))
      smode <= (w[7:0] != 8'hFF) || (pend != 8'h00);
    pend <= 8'h00;
    if (pend == 8'h40 || pend == 8'hC0) begin
      busy <= BUSY_CYC;
      if (sr[3] || i_vpen_low) sr[4:3] <= 2'b11;
      else if (i_locked) sr <= sr | 8'h12;
      else if (i_fail || (pend == 8'hC0 && (a < 24'h100 || a > 24'h111)))
        sr[4] <= 1'b1;
      else mem[int'(a)] = w;
    end else if (pend != 8'h00) begin
      busy <= BUSY_CYC;
      if (pend == 8'h60 && w[7:0] == 8'h01) sr[4] <= sr[4] | i_fail;
      else if (w[7:0] == 8'hD0) sr[5] <= sr[5] | i_fail;
      else sr[5:4] <= 2'b11;
    end else if (w[7:0] == CLEAR_CODE) sr <= sr & 8'hC5;
    else if (w[7:0] == 8'hB0 && busy > 0) begin
      held <= busy;
      busy <= 0;
      sr[6] <= 1'b1;
    end else if (w[7:0] == 8'hD0 && sr[6]) begin
      busy <= held;
      sr[6] <= 1'b0;
    end else if (w[7:0] != 8'hFF) pend <= w[7:0];
  endtask
  // Internal controller and edge detection of the strobes
  always @(negedge i_clock) begin
    cyc <= cyc + 1;
    oe_q <= i_oe_b;
    we_q <= i_we_b;
    if (busy > 0) busy <= busy - 1;
    if (i_rp_b !== 1'b1) begin
      sr <= 8'h00;
      pend <= 8'h00;
      smode <= 1'b0;
      busy <= 0;
    end else begin
      if (oe_q && !i_oe_b) shown <= {busy == 0, sr[6:0]};
      if (!we_q && i_we_b && !i_ce_b) take(i_addr, i_dq);
    end
  end
endmodule
`default_nettype wire

// ---- tb/flash_command_sequencer_bench.sv ----
// Self-checking bench of the flash host sequencer against a behavioural flash.
// Assumes one clock; expected status bytes queue up in order of completion.
`timescale 1ns/10ps
`default_nettype none
module flash_command_sequencer_bench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic valid = 1'b0;
  logic pd = 1'b0;
  logic vlow = 1'b0;
  logic lck = 1'b0;
  logic fail = 1'b0;
  fcs_pkg::fcs_op_t code = fcs_pkg::OP_CLEAR_STATUS;
  logic [23:0] addr = 24'h000000;
  logic [15:0] data = 16'h0000;
  logic rdy, srdy, done, dq_oe, ce_b, oe_b, we_b, rp_b, bl;
  logic [7:0] status;
  logic [6:0] flg;
  logic dbusy;
  logic [15:0] exp_st;
  logic [23:0] fa;
  logic [15:0] hdq, mdq;
  wire [15:0] dq_bus = dq_oe ? hdq : mdq;
  logic [15:0] q [$];
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  int seed = 32'hd08489e3;
  logic [23:0] ra;
  logic [15:0] rd;
  fcs_flash_host dut_u (.i_clock(clk), .i_rst_b(rst_b), .i_op_valid(valid), .i_op_code(code),
    .i_op_addr(addr), .i_op_data(data), .i_powerdown(pd), .o_op_ready(rdy),
    .o_suspend_ready(srdy), .o_op_done(done), .o_status(status), .o_device_ready(flg[6]),
    .o_suspended(flg[5]), .o_voltage_error(flg[2]), .o_protect_error(flg[1]),
    .o_program_error(flg[3]), .o_erase_error(flg[4]), .o_sequence_error(flg[0]),
    .o_device_busy(dbusy), .o_flash_addr(fa),
    .o_flash_dq(hdq), .o_flash_dq_oe(dq_oe), .i_flash_dq(dq_bus), .o_flash_ce_b(ce_b),
    .o_flash_oe_b(oe_b), .o_flash_we_b(we_b), .o_flash_rp_b(rp_b), .i_busy_indicator_pin(!bl));
  fcs_flash_model model (.i_clock(clk), .i_addr(fa), .i_dq(dq_bus), .i_ce_b(ce_b),
    .i_oe_b(oe_b), .i_we_b(we_b), .i_rp_b(rp_b), .i_vpen_low(vlow), .i_locked(lck),
    .i_fail(fail), .o_dq(mdq), .o_busy_low(bl));
  // Clock of 50 ns period
  initial forever #25 clk = ~clk;
  task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
    compares = compares + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Present one order; note the expected status only when a done will report it
  task automatic op(input fcs_pkg::fcs_op_t c, input logic [23:0] a, input logic [15:0] d,
      input logic [7:0] e, input bit note);
    if (note) q.push_back(16'(e));
    @(posedge clk);
    valid <= 1'b1;
    code <= c;
    addr <= a;
    data <= d;
    @(negedge clk);
    if (c == fcs_pkg::OP_SUSPEND) begin
      while (srdy !== 1'b1) @(negedge clk);
      while (srdy === 1'b1) @(negedge clk);
    end else while (rdy !== 1'b1) @(negedge clk);
    @(posedge clk);
    valid <= 1'b0;
  endtask
  task automatic tend(input string n);
    while (q.size() != 0) @(negedge clk);
    repeat (3) @(negedge clk);
    $display("Test %s done", n);
  endtask
  // Result watcher: status and read-array mode at every done pulse
  always @(negedge clk) begin
    if (done === 1'b1) begin
      if (q.size() == 0) begin
        check("unexpected done", 16'h0000, 16'hFFFF);
      end else begin
        exp_st = q.pop_front();
        check("status", exp_st, 16'(status));
        check("flags", 16'({exp_st[7:3], exp_st[1], exp_st[5] & exp_st[4]}), 16'(flg));
      end
      check("array mode", 16'h0000, 16'(model.smode));
      check("busy pin", 16'h0000, 16'(dbusy));
    end
  end
  // Hang guard, well above the longest expected run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches = mismatches + 1;
      end_of_test();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (20) @(posedge clk);
    op(fcs_pkg::OP_CLEAR_STATUS, 24'h0, 16'h0, 8'h00, 1);
    for (int i = 0; i < 3; i++) begin
      ra = 24'h010000 | 24'($random(seed) & 32'hFF);
      rd = 16'($random(seed));
      op(fcs_pkg::OP_PROGRAM, ra, rd, 8'h80, 1);
      repeat (40) @(negedge clk);
      check("busy pin", 16'h0001, 16'(dbusy));
      tend("program");
      check("array word", rd, model.mem[int'(ra)]);
    end
    vlow <= 1'b1;
    op(fcs_pkg::OP_PROGRAM, 24'h20, 16'h1234, 8'h98, 1);
    tend("low supply");
    vlow <= 1'b0;
    op(fcs_pkg::OP_PROGRAM, 24'h22, 16'h5678, 8'h98, 1);
    op(fcs_pkg::OP_CLEAR_STATUS, 24'h0, 16'h0, 8'h80, 1);
    tend("sticky voltage");
    lck <= 1'b1;
    op(fcs_pkg::OP_PROGRAM, 24'h24, 16'h0F0F, 8'h92, 1);
    tend("locked block");
    lck <= 1'b0;
    op(fcs_pkg::OP_CLEAR_STATUS, 24'h0, 16'h0, 8'h80, 1);
    op(fcs_pkg::OP_ERASE, 24'h020000, 16'h0, 8'h80, 1);
    op(fcs_pkg::OP_ERASE, 24'h040000, 16'h0, 8'h00, 0);
    op(fcs_pkg::OP_SUSPEND, 24'h0, 16'h0, 8'hC0, 1);
    op(fcs_pkg::OP_RESUME, 24'h0, 16'h0, 8'h80, 1);
    tend("erase suspend");
    op(fcs_pkg::OP_PROGRAM, 24'h30, 16'hA5A5, 8'h00, 0);
    op(fcs_pkg::OP_SUSPEND, 24'h0, 16'h0, 8'hC0, 1);
    op(fcs_pkg::OP_READ_ARRAY, 24'h40, 16'h0, 8'hC0, 1);
    op(fcs_pkg::OP_RESUME, 24'h0, 16'h0, 8'h80, 1);
    tend("program suspend");
    op(fcs_pkg::OP_LOCK_SET, 24'h020000, 16'h0, 8'h80, 1);
    tend("lock set");
    fail <= 1'b1;
    op(fcs_pkg::OP_LOCK_SET, 24'h020000, 16'h0, 8'h90, 1);
    op(fcs_pkg::OP_LOCK_CLEAR, 24'h0, 16'h0, 8'hB0, 1);
    tend("lock faults");
    fail <= 1'b0;
    op(fcs_pkg::OP_LOCK_SET, 24'h020000, 16'h0, 8'hB0, 1);
    op(fcs_pkg::OP_CLEAR_STATUS, 24'h0, 16'h0, 8'h80, 1);
    op(fcs_pkg::OP_PROT_PROGRAM, 24'h104, 16'h00AA, 8'h80, 1);
    op(fcs_pkg::OP_PROT_PROGRAM, 24'h200, 16'h00AA, 8'h90, 1);
    tend("protection");
    @(posedge clk);
    pd <= 1'b1;
    repeat (5) @(posedge clk);
    check("status after power-down", 16'h0000, 16'(status));
    pd <= 1'b0;
    repeat (20) @(posedge clk);
    op(fcs_pkg::OP_CLEAR_STATUS, 24'h0, 16'h0, 8'h00, 1);
    tend("power-down");
    end_of_test();
  end
endmodule
`default_nettype wire
